// >>> hdl/cmr_consts.svh
// Address map, field positions and reset values of the configuration and media status block.
`ifndef CMR_CONSTS_SVH
`define CMR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------------
`define CMR_ADDR_W        12
`define CMR_CFG_ADDR      12'h004
`define CMR_IRQ_STAT_ADDR 12'h010
`define CMR_IRQ_CLR_ADDR  12'h014
`define CMR_IRQ_EN_ADDR   12'h018

// ----------------------------------------------------------------------------
// Configuration and media status word
// ----------------------------------------------------------------------------
`define CMR_CFG_RESET     32'h0000_0000
`define CMR_CFG_WR_MASK   32'h00FF_F000
`define CMR_ZERO_WORD     32'h0000_0000
`define CMR_B_LINK        31
`define CMR_B_SPEED       30
`define CMR_B_FULL_DUPLEX_FLAG        29
`define CMR_B_POL         28
`define CMR_B_AUTONEG_COMPLETE_FLAG     27
`define CMR_B_PHYCFG_HI   23
`define CMR_B_PHYCFG_LO   18
`define CMR_B_ACEN        17
`define CMR_B_PAUSE       16
`define CMR_B_SEL_HI      15
`define CMR_B_SEL_LO      13
`define CMR_B_EXT         12

// ----------------------------------------------------------------------------
// Interrupt status, clear and enable layout
// ----------------------------------------------------------------------------
`define CMR_EV_W          3
`define CMR_EV_RESET      3'h0
`define CMR_EV_LINK       0
`define CMR_EV_ANEG       1
`define CMR_EV_PHYIRQ     2

// ----------------------------------------------------------------------------
// Synchronised phy status bundle
// ----------------------------------------------------------------------------
`define CMR_SYNC_W        6
`define CMR_SYNC_RESET    6'h00

`endif

// >>> hdl/cmr_pkg.sv
// Shared types of the configuration and media status block.
package cmr_pkg;
	typedef logic [31:0] cmr_word_t;
	typedef logic [2:0]  cmr_sel_t;
endpackage

// >>> hdl/cmr_sync3.sv
// Three-stage synchroniser whose output moves only when stages two and three agree.
`timescale 1ns/1ps
`include "cmr_consts.svh"

module cmr_sync3 (
	input  wire logic                   clk_i,
	input  wire logic                   resetn_i,
	input  wire logic                   ce_i,
	input  wire logic [`CMR_SYNC_W-1:0] async_i,
	output logic      [`CMR_SYNC_W-1:0] sync_o
);
	logic [`CMR_SYNC_W-1:0] s1_r;
	logic [`CMR_SYNC_W-1:0] s2_r;
	logic [`CMR_SYNC_W-1:0] s3_r;

	genvar g;
	generate
		for (g = 0; g < `CMR_SYNC_W; g++) begin : g_bit
			always_ff @(posedge clk_i) begin
				if (!resetn_i) begin
					s1_r[g]   <= 1'b0;
					s2_r[g]   <= 1'b0;
					s3_r[g]   <= 1'b0;
					sync_o[g] <= 1'b0;
				end else if (ce_i) begin
					s1_r[g] <= async_i[g];
					s2_r[g] <= s1_r[g];
					s3_r[g] <= s2_r[g];
					// A value is taken only once it has been stable for two samples.
					if (s2_r[g] == s3_r[g]) begin
						sync_o[g] <= s3_r[g];
					end
				end
			end
		end
	endgenerate
endmodule // cmr_sync3

// >>> hdl/cmr_aneg_decode.sv
// Turns the auto-negotiation select and pause bits into registered phy controls.
`timescale 1ns/1ps

module cmr_aneg_decode
	import cmr_pkg::*;
(
	input  wire logic     clk_i,
	input  wire logic     resetn_i,
	input  wire logic     ce_i,
	input  wire cmr_sel_t sel_i,
	input  wire logic     pause_i,
	output logic          autoneg_enable_o,
	output logic          force_fast_speed_flag_o,
	output logic          force_full_duplex_o,
	output logic          adv_10_half_o,
	output logic          adv_10_full_o,
	output logic          adv_100_half_o,
	output logic          adv_100_full_o,
	output logic          adv_pause_o
);
	logic [3:0] adv_nxt;

	always_comb begin
		case (sel_i)
			3'h1:    adv_nxt = 4'h3;
			3'h3:    adv_nxt = 4'h5;
			3'h5:    adv_nxt = 4'hC;
			3'h7:    adv_nxt = 4'hF;
			default: adv_nxt = 4'h0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			autoneg_enable_o    <= 1'b0;
			force_fast_speed_flag_o    <= 1'b0;
			force_full_duplex_o <= 1'b0;
			adv_10_half_o       <= 1'b0;
			adv_10_full_o       <= 1'b0;
			adv_100_half_o      <= 1'b0;
			adv_100_full_o      <= 1'b0;
			adv_pause_o         <= 1'b0;
		end else if (ce_i) begin
			autoneg_enable_o    <= sel_i[0];
			// Forced modes take speed from the middle bit and duplex from the top bit.
			force_fast_speed_flag_o    <= ~sel_i[0] & sel_i[1];
			force_full_duplex_o <= ~sel_i[0] & sel_i[2];
			adv_10_half_o       <= adv_nxt[0];
			adv_10_full_o       <= adv_nxt[1];
			adv_100_half_o      <= adv_nxt[2];
			adv_100_full_o      <= adv_nxt[3];
			adv_pause_o         <= pause_i & (adv_nxt[1] | adv_nxt[3]);
		end
	end
endmodule // cmr_aneg_decode

// >>> hdl/cmr_media_status.sv
// Configuration and media status register with its APB slave and interrupt logic.
//
// Function
// - Register at 0x0004, zero on hard/soft reset.
// - Bit 31 reads live link good status.
// - Bit 30 reads 100 Mb/s speed.
// - Bit 29 reads full duplex status.
// - Bit 28 reversed polarity, only at 10 Mb/s.
// - Bit 27 autoneg done or autoneg inactive.
// - Bits 23-18 drive phy power-on configuration.
// - Bit 17 set: status read clears phy irq.
// - Bit 17 clear: only phy access clears irq.
// - Bit 16 pause advertise, loaded from EEPROM.
// - Pause advertised only with full duplex advertised.
// - Bits 15-13 autoneg select, loaded from EEPROM.
// - Even select values force speed and duplex.
// - Odd select values enable autoneg with advertisement.
// - Bit 12 enables MII, disables internal phy.
// - Phy disable holds internal phy in low power.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "cmr_consts.svh"

module cmr_media_status
	import cmr_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  resetn_i,
	input  wire logic                  ce_i,
	input  wire logic                  soft_reset_i,
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [`CMR_ADDR_W-1:0] paddr_i,
	input  wire cmr_word_t             pwdata_i,
	output cmr_word_t                  prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	input  wire logic                  eeprom_load_i,
	input  wire logic                  eeprom_pause_advertise_i,
	input  wire cmr_sel_t              eeprom_autoneg_select_i,
	input  wire logic                  phy_link_good_i,
	input  wire logic                  phy_fast_speed_flag_i,
	input  wire logic                  phy_full_duplex_i,
	input  wire logic                  phy_pol_reversed_i,
	input  wire logic                  phy_autoneg_done_i,
	input  wire logic                  phy_irq_i,
	input  wire logic                  phy_reg_access_i,
	input  wire logic                  internal_phy_disable_i,
	output logic [5:0]                 phy_cfg_o,
	output logic                       phy_irq_autoclear_en_o,
	output logic                       phy_irq_pending_o,
	output logic                       autoneg_enable_o,
	output logic                       force_fast_speed_flag_o,
	output logic                       force_full_duplex_o,
	output logic                       adv_10_half_o,
	output logic                       adv_10_full_o,
	output logic                       adv_100_half_o,
	output logic                       adv_100_full_o,
	output logic                       adv_pause_o,
	output logic                       mii_enable_o,
	output logic                       internal_phy_disable_o,
	output logic                       phy_low_power_o,
	output logic                       irq_o
);

	// ------------------------------------------------------------------------
	// Phy status synchronisation
	// ------------------------------------------------------------------------
	// The phy status lines come from the phy's own clock, so all of them pass
	// the three-stage synchroniser before any logic looks at them.
	logic [`CMR_SYNC_W-1:0] phy_async;
	logic [`CMR_SYNC_W-1:0] phy_sync;
	logic                   link_good_flag;
	logic                   fast_speed_flag;
	logic                   full_duplex_flag;
	logic                   pol_raw;
	logic                   aneg_raw;
	logic                   phy_irq_sync;

	assign phy_async = {phy_irq_i, phy_autoneg_done_i, phy_pol_reversed_i,
		phy_full_duplex_i, phy_fast_speed_flag_i, phy_link_good_i};

	cmr_sync3 u_sync (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.ce_i     (ce_i),
		.async_i  (phy_async),
		.sync_o   (phy_sync)
	);

	assign link_good_flag   = phy_sync[0];
	assign fast_speed_flag  = phy_sync[1];
	assign full_duplex_flag = phy_sync[2];
	assign pol_raw          = phy_sync[3];
	assign aneg_raw         = phy_sync[4];
	assign phy_irq_sync     = phy_sync[5];

	// ------------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------------
	logic setup_phase;
	logic access_phase;
	logic hit_cfg;
	logic hit_stat;
	logic hit_clr;
	logic hit_en;
	logic addr_hit;
	logic wr_cfg;
	logic wr_clr;
	logic wr_en;
	logic rd_stat;

	assign setup_phase  = psel_i & ~penable_i;
	assign access_phase = psel_i & penable_i & ce_i;
	assign hit_cfg      = (paddr_i == `CMR_CFG_ADDR);
	assign hit_stat     = (paddr_i == `CMR_IRQ_STAT_ADDR);
	assign hit_clr      = (paddr_i == `CMR_IRQ_CLR_ADDR);
	assign hit_en       = (paddr_i == `CMR_IRQ_EN_ADDR);
	assign addr_hit     = hit_cfg | hit_stat | hit_clr | hit_en;
	assign wr_cfg       = access_phase & pwrite_i & hit_cfg;
	assign wr_clr       = access_phase & pwrite_i & hit_clr;
	assign wr_en        = access_phase & pwrite_i & hit_en;
	assign rd_stat      = access_phase & ~pwrite_i & hit_stat;

	// Zero-wait slave; a frozen block holds the access phase open instead.
	assign pready_o  = ce_i;
	assign pslverr_o = access_phase & ~addr_hit;

	// ------------------------------------------------------------------------
	// Configuration register
	// ------------------------------------------------------------------------
	cmr_word_t cfg_r;
	cmr_word_t cfg_nxt;

	always_comb begin
		cfg_nxt = cfg_r;
		if (soft_reset_i) begin
			cfg_nxt = `CMR_CFG_RESET;
		end else if (eeprom_load_i) begin
			// Power-up load has priority over a software write in the same cycle.
			cfg_nxt[`CMR_B_PAUSE] = eeprom_pause_advertise_i;
			cfg_nxt[`CMR_B_SEL_HI:`CMR_B_SEL_LO] = eeprom_autoneg_select_i;
		end else if (wr_cfg) begin
			// Read-only, unused and reserved positions are masked away.
			cfg_nxt = pwdata_i & `CMR_CFG_WR_MASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cfg_r <= `CMR_CFG_RESET;
		end else if (ce_i) begin
			cfg_r <= cfg_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// Live status view
	// ------------------------------------------------------------------------
	logic reversed_polarity_flag;
	logic autoneg_complete_flag;
	logic phy_irq_autoclear_en;
	logic external_phy_select;

	assign phy_irq_autoclear_en = cfg_r[`CMR_B_ACEN];
	assign external_phy_select  = cfg_r[`CMR_B_EXT];

	// Polarity has no meaning at 100 Mb/s, so it is masked there.
	assign reversed_polarity_flag = pol_raw & ~fast_speed_flag;
	// With the select field in a forced mode the negotiation is not active.
	assign autoneg_complete_flag  = aneg_raw | ~cfg_r[`CMR_B_SEL_LO];

	// ------------------------------------------------------------------------
	// Phy interrupt source
	// ------------------------------------------------------------------------
	logic phy_irq_pending_r;
	logic phy_irq_d_r;
	logic phy_irq_rise;
	logic phy_irq_clear;

	assign phy_irq_rise  = phy_irq_sync & ~phy_irq_d_r;
	assign phy_irq_clear = phy_reg_access_i | (rd_stat & phy_irq_autoclear_en);

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			phy_irq_d_r <= 1'b0;
		end else if (ce_i) begin
			phy_irq_d_r <= phy_irq_sync;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			phy_irq_pending_r <= 1'b0;
		end else if (ce_i) begin
			// A new phy event in the clearing cycle keeps the source pending.
			if (phy_irq_rise) begin
				phy_irq_pending_r <= 1'b1;
			end else if (phy_irq_clear) begin
				phy_irq_pending_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Interrupt status, clear and enable
	// ------------------------------------------------------------------------
	logic                 link_d_r;
	logic                 aneg_d_r;
	logic [`CMR_EV_W-1:0] events;
	logic [`CMR_EV_W-1:0] irq_stat_r;
	logic [`CMR_EV_W-1:0] irq_stat_nxt;
	logic [`CMR_EV_W-1:0] irq_en_r;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			link_d_r <= 1'b0;
			// The done flag reads set out of reset, so a low start would log a false rise.
			aneg_d_r <= 1'b1;
		end else if (ce_i) begin
			link_d_r <= link_good_flag;
			aneg_d_r <= autoneg_complete_flag;
		end
	end

	always_comb begin
		events = `CMR_EV_RESET;
		events[`CMR_EV_LINK]   = link_good_flag ^ link_d_r;
		events[`CMR_EV_ANEG]   = autoneg_complete_flag & ~aneg_d_r;
		events[`CMR_EV_PHYIRQ] = phy_irq_rise;
	end

	always_comb begin
		irq_stat_nxt = irq_stat_r;
		if (wr_clr) begin
			irq_stat_nxt = irq_stat_r & ~pwdata_i[`CMR_EV_W-1:0];
		end
		// Set wins over clear so that no event is lost.
		irq_stat_nxt = irq_stat_nxt | events;
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			irq_stat_r <= `CMR_EV_RESET;
		end else if (ce_i) begin
			irq_stat_r <= irq_stat_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			irq_en_r <= `CMR_EV_RESET;
		end else if (ce_i && wr_en) begin
			irq_en_r <= pwdata_i[`CMR_EV_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			irq_o <= 1'b0;
		end else if (ce_i) begin
			irq_o <= |(irq_stat_nxt & irq_en_r);
		end
	end

	// ------------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------------
	cmr_word_t rd_word;

	always_comb begin
		rd_word = `CMR_ZERO_WORD;
		if (hit_cfg) begin
			// Bits below the external phy select belong to another register block.
			rd_word = cfg_r & `CMR_CFG_WR_MASK;
			rd_word[`CMR_B_LINK]    = link_good_flag;
			rd_word[`CMR_B_SPEED]   = fast_speed_flag;
			rd_word[`CMR_B_FULL_DUPLEX_FLAG]    = full_duplex_flag;
			rd_word[`CMR_B_POL]     = reversed_polarity_flag;
			rd_word[`CMR_B_AUTONEG_COMPLETE_FLAG] = autoneg_complete_flag;
		end else if (hit_stat) begin
			rd_word[`CMR_EV_W-1:0] = irq_stat_r;
		end else if (hit_en) begin
			rd_word[`CMR_EV_W-1:0] = irq_en_r;
		end
	end

	// Read data is captured in the setup cycle and held through the access phase.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			prdata_o <= `CMR_ZERO_WORD;
		end else if (ce_i && setup_phase && !pwrite_i) begin
			prdata_o <= rd_word;
		end
	end

	// ------------------------------------------------------------------------
	// Phy controls
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			phy_cfg_o              <= 6'h00;
			phy_irq_autoclear_en_o <= 1'b0;
			phy_irq_pending_o      <= 1'b0;
			mii_enable_o           <= 1'b0;
			internal_phy_disable_o <= 1'b0;
			phy_low_power_o        <= 1'b0;
		end else if (ce_i) begin
			phy_cfg_o              <= cfg_r[`CMR_B_PHYCFG_HI:`CMR_B_PHYCFG_LO];
			phy_irq_autoclear_en_o <= phy_irq_autoclear_en;
			phy_irq_pending_o      <= phy_irq_pending_r;
			mii_enable_o           <= external_phy_select;
			internal_phy_disable_o <= external_phy_select;
			// Either source of the disable parks the phy in low power.
			phy_low_power_o        <= internal_phy_disable_i | external_phy_select;
		end
	end

	// The pause bit is passed through as written; the decode drops it unless a full-duplex mode is advertised.
	cmr_aneg_decode u_decode (
		.clk_i               (clk_i),
		.resetn_i            (resetn_i),
		.ce_i                (ce_i),
		.sel_i               (cfg_r[`CMR_B_SEL_HI:`CMR_B_SEL_LO]),
		.pause_i             (cfg_r[`CMR_B_PAUSE]),
		.autoneg_enable_o    (autoneg_enable_o),
		.force_fast_speed_flag_o    (force_fast_speed_flag_o),
		.force_full_duplex_o (force_full_duplex_o),
		.adv_10_half_o       (adv_10_half_o),
		.adv_10_full_o       (adv_10_full_o),
		.adv_100_half_o      (adv_100_half_o),
		.adv_100_full_o      (adv_100_full_o),
		.adv_pause_o         (adv_pause_o)
	);

endmodule // cmr_media_status

// >>> sim/cmr_media_status_props.sv
// Assertion checker for the configuration and media status block.
`timescale 1ns/1ps
`include "cmr_consts.svh"

module cmr_media_status_props
	import cmr_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        resetn_i,
	input wire logic        ce_i,
	input wire logic        soft_reset_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire cmr_word_t   pwdata_i,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        eeprom_load_i,
	input wire cmr_sel_t    eeprom_autoneg_select_i,
	input wire logic        internal_phy_disable_i,
	input wire logic [5:0]  phy_cfg_o,
	input wire logic        phy_irq_autoclear_en_o,
	input wire logic        autoneg_enable_o,
	input wire logic        adv_10_half_o,
	input wire logic        adv_10_full_o,
	input wire logic        adv_100_half_o,
	input wire logic        adv_100_full_o,
	input wire logic        adv_pause_o,
	input wire logic        mii_enable_o,
	input wire logic        internal_phy_disable_o,
	input wire logic        phy_low_power_o,
	input wire logic        irq_o
);
	logic mapped;
	logic wr_cfg;

	// Soft reset and the EEPROM load outrank a bus write, so only a lone write is judged here.
	assign mapped = paddr_i inside {`CMR_CFG_ADDR, `CMR_IRQ_STAT_ADDR, `CMR_IRQ_CLR_ADDR, `CMR_IRQ_EN_ADDR};
	assign wr_cfg = psel_i & penable_i & pwrite_i & ce_i & ~soft_reset_i & ~eeprom_load_i & (paddr_i == `CMR_CFG_ADDR);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	AST_PREADY: assert property (
		pready_o == ce_i) else $error("ready differs from clock enable");
	AST_PSLVERR: assert property (
		pslverr_o == (psel_i & penable_i & ce_i & ~mapped)) else $error("error flag wrong for address");
	AST_WRCFG: assert property (
		wr_cfg ##1 ce_i |=>
		{8'h00, phy_cfg_o, phy_irq_autoclear_en_o, 4'h0, mii_enable_o, 12'h000} == ($past(pwdata_i, 2) & 32'h00FE_1000))
		else $error("config outputs do not follow write");
	AST_SEL: assert property (
		wr_cfg ##1 ce_i |=> autoneg_enable_o == $past(pwdata_i[13], 2))
		else $error("autoneg enable wrong after write");
	AST_EXTPAIR: assert property (
		internal_phy_disable_o == mii_enable_o) else $error("phy disable request differs from mii enable");
	AST_FORCED: assert property (
		!autoneg_enable_o |-> !(adv_10_half_o | adv_10_full_o | adv_100_half_o | adv_100_full_o | adv_pause_o))
		else $error("advertisement while autoneg disabled");
	AST_PAUSE: assert property (
		adv_pause_o |-> (adv_10_full_o | adv_100_full_o)) else $error("pause advertised without full duplex");
	AST_SOFT: assert property (
		soft_reset_i & ce_i ##1 ce_i |=> (phy_cfg_o == 6'h00) && !mii_enable_o && !phy_irq_autoclear_en_o)
		else $error("soft reset left config set");
	AST_EEPROM: assert property (
		eeprom_load_i & ce_i & ~soft_reset_i ##1 ce_i |=> autoneg_enable_o == $past(eeprom_autoneg_select_i[0], 2))
		else $error("eeprom select not loaded");
	AST_LOWPWR: assert property (
		ce_i & internal_phy_disable_i |=> phy_low_power_o) else $error("phy not in low power");

	COV_WR: cover property (wr_cfg);
	COV_ERR: cover property (pslverr_o);
	COV_IRQ: cover property ($rose(irq_o));
endmodule // cmr_media_status_props

bind cmr_media_status cmr_media_status_props u_props (.clk_i, .resetn_i, .ce_i, .soft_reset_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o, .eeprom_load_i, .eeprom_autoneg_select_i,
	.internal_phy_disable_i, .phy_cfg_o, .phy_irq_autoclear_en_o, .autoneg_enable_o, .adv_10_half_o, .adv_10_full_o,
	.adv_100_half_o, .adv_100_full_o, .adv_pause_o, .mii_enable_o, .internal_phy_disable_o, .phy_low_power_o, .irq_o);

// >>> sim/cmr_media_status_bench.sv
// Self-checking bench for the configuration and media status block.
`timescale 1ns/1ps
`include "cmr_consts.svh"

module cmr_media_status_bench
	import cmr_pkg::*;
;
	logic       clk_i, resetn_i, ce_i, soft_reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [11:0] paddr_i;
	cmr_word_t  pwdata_i, prdata_o, rd, w;
	logic       eeprom_load_i, eeprom_pause_advertise_i, err;
	cmr_sel_t   eeprom_autoneg_select_i;
	logic       phy_link_good_i, phy_fast_speed_flag_i, phy_full_duplex_i, phy_pol_reversed_i, phy_autoneg_done_i;
	logic       phy_irq_i, phy_reg_access_i, internal_phy_disable_i, phy_irq_autoclear_en_o, phy_irq_pending_o;
	logic [5:0] phy_cfg_o;
	logic       autoneg_enable_o, force_fast_speed_flag_o, force_full_duplex_o, adv_10_half_o, adv_10_full_o;
	logic       adv_100_half_o, adv_100_full_o, adv_pause_o, mii_enable_o, internal_phy_disable_o;
	logic       phy_low_power_o, irq_o;
	int         fail_count, check_count, n;
	// Row: select, phy status {link, speed, duplex, polarity, done}, expected decode vector.
	logic [15:0] rows [8] = '{16'h1600, 16'h2B98, 16'h4040, 16'h7C94, 16'h8220, 16'hB186, 16'hCE60, 16'hFF9E};

	cmr_media_status dut (.clk_i, .resetn_i, .ce_i, .soft_reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .eeprom_load_i, .eeprom_pause_advertise_i,
		.eeprom_autoneg_select_i, .phy_link_good_i, .phy_fast_speed_flag_i, .phy_full_duplex_i, .phy_pol_reversed_i,
		.phy_autoneg_done_i, .phy_irq_i, .phy_reg_access_i, .internal_phy_disable_i, .phy_cfg_o,
		.phy_irq_autoclear_en_o, .phy_irq_pending_o, .autoneg_enable_o, .force_fast_speed_flag_o, .force_full_duplex_o,
		.adv_10_half_o, .adv_10_full_o, .adv_100_half_o, .adv_100_full_o, .adv_pause_o, .mii_enable_o,
		.internal_phy_disable_o, .phy_low_power_o, .irq_o);

	// Polarity reads set only at 10 Mb/s; done also reads set when the select disables autoneg.
	function automatic cmr_word_t cfgexp(input cmr_word_t s, input logic [4:0] st);
		return {st[4], st[3], st[2], st[1] & ~st[3], st[0] | ~s[13], 3'b000, s[23:12], 12'h000};
	endfunction

	task automatic summarize();
		if (fail_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input cmr_word_t seen, input cmr_word_t exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One idle cycle leads each transfer so no strobe is driven twice in one time step.
	task automatic apb(input logic wr, input logic [11:0] a, input cmr_word_t d);
		int i;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (pready_o === 1'b1) break;
		end
		if (i == 20) begin
			fail_count++;
			summarize();
		end else begin
			rd = prdata_o;
			err = pslverr_o;
			psel_i <= 1'b0;
			penable_i <= 1'b0;
		end
	endtask

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	initial begin
		{resetn_i, soft_reset_i, psel_i, penable_i, pwrite_i, eeprom_load_i, eeprom_pause_advertise_i} = '0;
		{phy_link_good_i, phy_fast_speed_flag_i, phy_full_duplex_i, phy_pol_reversed_i, phy_autoneg_done_i} = '0;
		{phy_irq_i, phy_reg_access_i, internal_phy_disable_i, paddr_i, pwdata_i, eeprom_autoneg_select_i} = '0;
		ce_i = 1'b1;
		repeat (6) @(posedge clk_i);
		resetn_i <= 1'b1;
		apb(0, `CMR_CFG_ADDR, 0);
		check(rd, cfgexp(0, 5'h00));
		apb(0, `CMR_IRQ_STAT_ADDR, 0);
		check(rd, 32'h0);
		for (n = 0; n < 8; n++) begin
			w = 32'hFF00_0FFF | {8'h00, 6'h15 ^ {3'h0, rows[n][15:13]}, rows[n][13], 1'b0, rows[n][15:13],
				rows[n][14], 12'h000};
			{phy_link_good_i, phy_fast_speed_flag_i, phy_full_duplex_i, phy_pol_reversed_i, phy_autoneg_done_i} <= rows[n][12:8];
			apb(1, `CMR_CFG_ADDR, w);
			repeat (4) @(posedge clk_i);
			apb(0, `CMR_CFG_ADDR, 0);
			check(rd, cfgexp(w & `CMR_CFG_WR_MASK, rows[n][12:8]));
			check({24'h0, autoneg_enable_o, force_fast_speed_flag_o, force_full_duplex_o, adv_10_half_o, adv_10_full_o,
				adv_100_half_o, adv_100_full_o, adv_pause_o}, {24'h0, rows[n][7:0]});
			check({26'h0, phy_cfg_o}, {26'h0, w[23:18]});
			check({28'h0, phy_irq_autoclear_en_o, mii_enable_o, internal_phy_disable_o, phy_low_power_o},
				{28'h0, w[17], w[12], w[12], w[12]});
		end
		apb(1, 12'h020, 32'hFFFF_FFFF);
		check({31'h0, err}, 32'h1);
		apb(0, 12'h020, 0);
		check({rd[30:0], err}, 32'h1);
		@(posedge clk_i);
		soft_reset_i <= 1'b1;
		@(posedge clk_i);
		soft_reset_i <= 1'b0;
		apb(0, `CMR_CFG_ADDR, 0);
		check(rd, cfgexp(0, 5'h1F));
		eeprom_pause_advertise_i <= 1'b1;
		eeprom_autoneg_select_i <= 3'h5;
		eeprom_load_i <= 1'b1;
		@(posedge clk_i);
		eeprom_load_i <= 1'b0;
		apb(0, `CMR_CFG_ADDR, 0);
		check(rd, cfgexp(32'h0001_A000, 5'h1F));
		check({31'h0, adv_pause_o}, 32'h1);
		ce_i <= 1'b0;
		soft_reset_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		check({31'h0, pready_o}, 32'h0);
		soft_reset_i <= 1'b0;
		ce_i <= 1'b1;
		apb(0, `CMR_CFG_ADDR, 0);
		check(rd, cfgexp(32'h0001_A000, 5'h1F));
		apb(1, `CMR_IRQ_CLR_ADDR, 32'h7);
		apb(1, `CMR_IRQ_EN_ADDR, 32'h1);
		phy_link_good_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		check({31'h0, irq_o}, 32'h1);
		apb(1, `CMR_IRQ_EN_ADDR, 32'h0);
		apb(0, `CMR_IRQ_STAT_ADDR, 0);
		check({irq_o, rd[30:0]}, 32'h1);
		apb(1, `CMR_IRQ_EN_ADDR, 32'h1);
		apb(0, `CMR_IRQ_CLR_ADDR, 0);
		check({irq_o, rd[30:0]}, 32'h8000_0000);
		apb(1, `CMR_IRQ_CLR_ADDR, 32'h1);
		repeat (2) @(posedge clk_i);
		check({31'h0, irq_o}, 32'h0);
		apb(1, `CMR_CFG_ADDR, 32'h0);
		phy_irq_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		apb(0, `CMR_IRQ_STAT_ADDR, 0);
		@(posedge clk_i);
		check({31'h0, phy_irq_pending_o}, 32'h1);
		phy_reg_access_i <= 1'b1;
		@(posedge clk_i);
		phy_reg_access_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		check({31'h0, phy_irq_pending_o}, 32'h0);
		apb(1, `CMR_CFG_ADDR, 32'h0002_0000);
		phy_irq_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		phy_irq_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		check({31'h0, phy_irq_pending_o}, 32'h1);
		apb(0, `CMR_IRQ_STAT_ADDR, 0);
		repeat (2) @(posedge clk_i);
		check({31'h0, phy_irq_pending_o}, 32'h0);
		internal_phy_disable_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		check({31'h0, phy_low_power_o}, 32'h1);
		summarize();
	end
endmodule // cmr_media_status_bench
